/* design/dgr_fv_qual.sv */
// Frame valid qualification and first line handling for one port
`timescale 1ns/1ps
`default_nettype none
module dgr_fv_qual (
    // Clock and reset
    input wire logic clock_in,
    input wire logic rst_n_in,
    // Polarity-corrected sync from the receiver
    input wire logic fv_in,
    input wire logic lv_in,
    // Configuration
    input wire logic [7:0] min_in,
    input wire logic keep_in,
    // Qualified sync
    output logic fv_ok_out,
    output logic lv_out
);
    dgr_pkg::dgr_qual_t state_reg, state_next;
    logic [7:0] cnt_reg;
    logic lv_d_reg;
    logic met;
    assign met = cnt_reg >= min_in;

    // Frame state; setup is judged at the first line only
    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            // A line already high as the frame opens is the first line, with no setup
            dgr_pkg::Q_IDLE: begin
                if (fv_in && !lv_in) begin
                    state_next = dgr_pkg::Q_COUNT;
                end else if (fv_in) begin
                    state_next = (min_in == 8'h00 || keep_in) ? dgr_pkg::Q_LINE
                        : dgr_pkg::Q_DROP;
                end
            end
            dgr_pkg::Q_COUNT: begin
                if (!fv_in) state_next = dgr_pkg::Q_IDLE;
                else if (lv_in && !lv_d_reg)
                    state_next = (met || keep_in) ? dgr_pkg::Q_LINE : dgr_pkg::Q_DROP;
            end
            dgr_pkg::Q_DROP: begin
                if (!fv_in) state_next = dgr_pkg::Q_IDLE;
                else if (!lv_in) state_next = dgr_pkg::Q_LINE;
            end
            dgr_pkg::Q_LINE: if (!fv_in) state_next = dgr_pkg::Q_IDLE;
        endcase
    end

    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            state_reg <= dgr_pkg::Q_IDLE;
            lv_d_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            lv_d_reg <= lv_in;
        end
    end

    // Saturating count of frame valid cycles before the first line
    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            cnt_reg <= 8'h00;
        end else if (state_reg != dgr_pkg::Q_COUNT) begin
            cnt_reg <= 8'h00;
        end else if (cnt_reg != 8'hff) begin
            cnt_reg <= cnt_reg + 8'h01;
        end
    end

    // Registered outputs
    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            fv_ok_out <= 1'b0;
            lv_out <= 1'b0;
        end else begin
            fv_ok_out <= fv_in && (met || state_reg != dgr_pkg::Q_COUNT)
                && state_reg != dgr_pkg::Q_IDLE;
            lv_out <= lv_in && state_next == dgr_pkg::Q_LINE;
        end
    end

    default clocking cb @(posedge clock_in); endclocking
    default disable iff (!rst_n_in);
    a_short_line_drop: assert property (
        (state_reg == dgr_pkg::Q_COUNT && fv_in && lv_in && !lv_d_reg && !met && !keep_in)
        |=> !lv_out [*2]) else $error("short first line was forwarded");
    c_line_dropped: cover property (state_reg == dgr_pkg::Q_DROP);
endmodule
`default_nettype wire

/* design/dgr_gpio_top.sv */
// Deserializer general-purpose pin routing top
// Behaviour
// - Pin control byte: function 7:5, source 4:2, value bit 1, enable bit 0.
// - Enable bit clear leaves pins other than pin 3 undriven whatever other fields hold.
// - Source 000 outputs port 0 forward GPIO 0-3, lock, pass, frame, line valid.
// - Source 001 outputs the same eight signals taken from port 1.
// - Source 100 function 000 drives the register value bit.
// - Source 100 codes 001-011: OR lock, AND lock, AND pass over enabled ports.
// - Source 100 codes 100-110: frame sync, interrupt high, interrupt low.
// - Source 101: pass AND/OR, recovered frame/line valid, port sync, transmit irq.
// - Each port carries four forward GPIOs, any mappable to any pin.
// - Forward GPIO updates every 1, 2 or 5 frames for 1, 2, 3-4 linked.
// - Any pin may feed any of four back-channel slots per port.
// - Back-channel slots are sampled once per 30-bit back-channel frame.
// - Frame sync is selectable as the source of any back-channel slot.
// - After reset pins other than pin 3 are inputs with input path and pulldown enabled.
// - Frame and line valid polarity is set per port.
// - Frame valid counts once a programmed minimum setup has passed or the first line has arrived.
// - A short setup drops the first line unless the keep bit forwards it.
// - In raw modes frame valid acts as vertical and line valid as horizontal sync.
// - Pin status returns the level of all seven pins, inputs or outputs.
// - Pin 3 is active-low open drain shared with the interrupt, no input controls.
`timescale 1ns/1ps
`default_nettype none
module dgr_gpio_top (
    // Clock and reset
    input wire logic clock_in,
    input wire logic rst_b_in,
    // Register access port
    input wire logic [7:0] reg_addr_in,
    input wire logic [7:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    output logic [7:0] reg_rd_data_out,
    // General-purpose pins
    input wire logic [6:0] pin_in,
    output logic [6:0] pin_out,
    output logic [6:0] pin_oe_out,
    output logic [6:0] pin_pulldown_out,
    // Forward channel from the receive ports
    input wire logic [3:0] fc_gpio_p0_in,
    input wire logic [3:0] fc_gpio_p1_in,
    input wire logic [1:0] fwd_frame_tick_in,
    input wire logic [1:0] forward_slot_count_p0_in,
    input wire logic [1:0] forward_slot_count_p1_in,
    // Receive port status
    input wire logic [1:0] port_enable_in,
    input wire logic [1:0] lock_in,
    input wire logic [1:0] pass_in,
    input wire logic [1:0] frame_valid_in,
    input wire logic [1:0] line_valid_in,
    input wire logic ports_synced_in,
    // Device events
    input wire logic frame_sync_pulse_in,
    input wire logic dev_irq_in,
    input wire logic csi_irq_in,
    // Back channel
    input wire logic [1:0] bc_frame_tick_in,
    output logic [3:0] bc_slot_p0_out,
    output logic [3:0] bc_slot_p1_out,
    // Qualified video sync per port
    output logic [1:0] frame_valid_ok_out,
    output logic [1:0] line_valid_ok_out
);
    logic rst_s1_reg, rst_n_reg;
    logic [6:0] pin_s1_reg, pin_sync_reg;
    logic [7:0] input_en_reg, pulldown_reg, slot_lo_reg, slot_hi_reg;
    logic [7:0] sync_pol_reg, fv_min_reg;
    logic [7:0] pin_ctl_reg [dgr_pkg::NPINS];
    logic [3:0] fc_reg [dgr_pkg::NPORTS];
    logic [2:0] fwd_cnt_reg [dgr_pkg::NPORTS];
    logic [3:0] bc_slot_reg [dgr_pkg::NPORTS];
    logic [1:0] fv_pol, lv_pol;
    logic [6:0] drive, level, pin_gated;
    logic [15:0] slot_map;
    logic [3:0] slot_val;
    logic [7:0] rd_mux;
    dgr_stat_if st ();

    // Reset release through two flip-flops
    always_ff @(posedge clock_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            rst_s1_reg <= 1'b0;
            rst_n_reg <= 1'b0;
        end else begin
            rst_s1_reg <= 1'b1;
            rst_n_reg <= rst_s1_reg;
        end
    end

    // Pins come from outside the clock domain
    always_ff @(posedge clock_in or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            pin_s1_reg <= 7'h00;
            pin_sync_reg <= 7'h00;
        end else begin
            pin_s1_reg <= pin_in;
            pin_sync_reg <= pin_s1_reg;
        end
    end

    // Register writes; pin 3 has no input or pulldown control
    always_ff @(posedge clock_in or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            input_en_reg <= dgr_pkg::RST_INPUT_EN;
            pulldown_reg <= dgr_pkg::RST_PULLDOWN;
            slot_lo_reg <= dgr_pkg::RST_SLOT;
            slot_hi_reg <= dgr_pkg::RST_SLOT;
            sync_pol_reg <= dgr_pkg::RST_SYNC_POL;
            fv_min_reg <= dgr_pkg::RST_FV_MIN;
        end else if (reg_wr_in) begin
            unique case (reg_addr_in)
                dgr_pkg::OFF_INPUT_EN: input_en_reg <= {1'b0, reg_wdata_in[6:0]}
                    | (8'h01 << dgr_pkg::INT_PIN);
                dgr_pkg::OFF_PULLDOWN: pulldown_reg <= {1'b0, reg_wdata_in[6:0]}
                    & ~(8'h01 << dgr_pkg::INT_PIN);
                dgr_pkg::OFF_SLOT_LO: slot_lo_reg <= reg_wdata_in;
                dgr_pkg::OFF_SLOT_HI: slot_hi_reg <= reg_wdata_in;
                dgr_pkg::OFF_SYNC_POL: sync_pol_reg <= reg_wdata_in;
                dgr_pkg::OFF_FV_MIN: fv_min_reg <= reg_wdata_in;
                default: ;
            endcase
        end
    end

    // Pin control bytes, one per pin
    always_ff @(posedge clock_in or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            for (int i = 0; i < dgr_pkg::NPINS; i++) pin_ctl_reg[i] <= dgr_pkg::RST_PIN_CTL;
        end else if (reg_wr_in && reg_addr_in >= dgr_pkg::OFF_PIN0_CTL
                && reg_addr_in <= dgr_pkg::OFF_PIN6_CTL) begin
            pin_ctl_reg[3'(reg_addr_in - dgr_pkg::OFF_PIN0_CTL)] <= reg_wdata_in;
        end
    end

    // Read data; unmapped offsets read zero
    always_comb begin
        rd_mux = 8'h00;
        if (reg_addr_in >= dgr_pkg::OFF_PIN0_CTL && reg_addr_in <= dgr_pkg::OFF_PIN6_CTL) begin
            rd_mux = pin_ctl_reg[3'(reg_addr_in - dgr_pkg::OFF_PIN0_CTL)];
        end else begin
            unique case (reg_addr_in)
                dgr_pkg::OFF_PIN_STATUS: rd_mux = {1'b0, pin_sync_reg};
                dgr_pkg::OFF_INPUT_EN: rd_mux = input_en_reg;
                dgr_pkg::OFF_PULLDOWN: rd_mux = pulldown_reg;
                dgr_pkg::OFF_SLOT_LO: rd_mux = slot_lo_reg;
                dgr_pkg::OFF_SLOT_HI: rd_mux = slot_hi_reg;
                dgr_pkg::OFF_SYNC_POL: rd_mux = sync_pol_reg;
                dgr_pkg::OFF_FV_MIN: rd_mux = fv_min_reg;
                default: rd_mux = 8'h00;
            endcase
        end
    end

    // Read data is held until the next read strobe
    always_ff @(posedge clock_in or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            reg_rd_data_out <= 8'h00;
        end else if (reg_rd_in) begin
            reg_rd_data_out <= rd_mux;
        end
    end

    // Forward GPIO capture; more linked GPIOs share frames, so updates slow down
    generate
        for (genvar p = 0; p < dgr_pkg::NPORTS; p++) begin : g_fwd
            logic [1:0] cnt_sel;
            logic [3:0] fc_raw;
            logic [2:0] div;
            assign cnt_sel = p == 0 ? forward_slot_count_p0_in : forward_slot_count_p1_in;
            assign fc_raw = p == 0 ? fc_gpio_p0_in : fc_gpio_p1_in;
            assign div = cnt_sel == 2'h0 ? dgr_pkg::FWD_DIV_ONE
                : cnt_sel == 2'h1 ? dgr_pkg::FWD_DIV_TWO : dgr_pkg::FWD_DIV_MANY;
            always_ff @(posedge clock_in or negedge rst_n_reg) begin
                if (!rst_n_reg) begin
                    fwd_cnt_reg[p] <= 3'h0;
                    fc_reg[p] <= 4'h0;
                end else if (fwd_frame_tick_in[p]) begin
                    if (fwd_cnt_reg[p] + 3'h1 >= div) begin
                        fwd_cnt_reg[p] <= 3'h0;
                        fc_reg[p] <= fc_raw;
                    end else begin
                        fwd_cnt_reg[p] <= fwd_cnt_reg[p] + 3'h1;
                    end
                end
            end
        end
    endgenerate

    // Back-channel slots: disabled inputs read low, select 7 picks frame sync
    assign pin_gated = pin_sync_reg & input_en_reg[6:0];
    assign slot_map = {slot_hi_reg, slot_lo_reg};
    generate
        for (genvar s = 0; s < dgr_pkg::NSLOTS; s++) begin : g_slot
            logic [2:0] sel;
            assign sel = slot_map[4 * s +: 3];
            assign slot_val[s] = sel == dgr_pkg::SLOT_FSYNC ? frame_sync_pulse_in
                : pin_gated[sel];
        end
        for (genvar p = 0; p < dgr_pkg::NPORTS; p++) begin : g_bc
            always_ff @(posedge clock_in or negedge rst_n_reg) begin
                if (!rst_n_reg) begin
                    bc_slot_reg[p] <= 4'h0;
                end else if (bc_frame_tick_in[p]) begin
                    bc_slot_reg[p] <= slot_val;
                end
            end
        end
    endgenerate
    assign bc_slot_p0_out = bc_slot_reg[0];
    assign bc_slot_p1_out = bc_slot_reg[1];

    // Per-port polarity, then frame valid qualification
    generate
        for (genvar p = 0; p < dgr_pkg::NPORTS; p++) begin : g_port
            assign fv_pol[p] = frame_valid_in[p] ^ sync_pol_reg[2 * p];
            assign lv_pol[p] = line_valid_in[p] ^ sync_pol_reg[2 * p + 1];
            dgr_fv_qual u_qual (
                .clock_in(clock_in),
                .rst_n_in(rst_n_reg),
                .fv_in(fv_pol[p]),
                .lv_in(lv_pol[p]),
                .min_in(fv_min_reg),
                .keep_in(sync_pol_reg[dgr_pkg::KEEP_LSB + p]),
                .fv_ok_out(frame_valid_ok_out[p]),
                .lv_out(line_valid_ok_out[p])
            );
        end
    endgenerate

    // Status bundle for the selectors
    assign st.fc0 = fc_reg[0];
    assign st.fc1 = fc_reg[1];
    assign st.lock = lock_in;
    assign st.pass = pass_in;
    assign st.fv = fv_pol;
    assign st.lv = lv_pol;
    assign st.en = port_enable_in;
    assign st.fsync = frame_sync_pulse_in;
    assign st.irq = dev_irq_in;
    assign st.csi_irq = csi_irq_in;
    assign st.synced = ports_synced_in;
    assign st.rec_fv = |(frame_valid_ok_out & port_enable_in);
    assign st.rec_lv = |(line_valid_ok_out & port_enable_in);

    // One selector per pin
    generate
        for (genvar i = 0; i < dgr_pkg::NPINS; i++) begin : g_pin
            dgr_pin_mux u_mux (
                .ctl_in(pin_ctl_reg[i]),
                .st(st),
                .drive_out(drive[i]),
                .level_out(level[i])
            );
        end
    endgenerate

    // Registered pin drive; pin 3 only pulls low, and carries the interrupt when idle
    always_ff @(posedge clock_in or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            pin_out <= 7'h00;
            pin_oe_out <= 7'h00;
            pin_pulldown_out <= 7'h00;
        end else begin
            for (int i = 0; i < dgr_pkg::NPINS; i++) begin
                if (i == dgr_pkg::INT_PIN) begin
                    pin_out[i] <= 1'b0;
                    pin_oe_out[i] <= drive[i] ? !level[i] : dev_irq_in;
                    pin_pulldown_out[i] <= 1'b0;
                end else begin
                    pin_out[i] <= drive[i] & level[i];
                    pin_oe_out[i] <= drive[i];
                    pin_pulldown_out[i] <= pulldown_reg[i] & !drive[i];
                end
            end
        end
    end

    default clocking cb @(posedge clock_in); endclocking
    default disable iff (!rst_n_reg);
    a_oe_follows_enable: assert property (!pin_ctl_reg[0][0] |=> !pin_oe_out[0])
        else $error("pin 0 driven while disabled");
    a_fixed_level_out: assert property (pin_ctl_reg[1] == 8'h13 |=> pin_oe_out[1] && pin_out[1])
        else $error("pin 1 register level not driven high");
    a_reserved_src_off: assert property (pin_ctl_reg[2][4:2] == 3'h2 |=> !pin_oe_out[2])
        else $error("reserved source drove pin 2");
    a_lock_or_out: assert property (pin_ctl_reg[0] == 8'h31 |=> pin_out[0] ==
        $past(|(lock_in & port_enable_in))) else $error("lock OR not on pin 0");
    a_status_read: assert property (reg_rd_in && reg_addr_in == 8'h0e |=>
        reg_rd_data_out == {1'b0, $past(pin_sync_reg)}) else $error("pin status mismatch");
    a_bc_sample: assert property (bc_frame_tick_in[0] |=>
        bc_slot_p0_out == $past(slot_val)) else $error("slot not sampled on tick");
    a_bc_hold: assert property (!bc_frame_tick_in[1] |=> $stable(bc_slot_p1_out))
        else $error("slot changed between ticks");
    a_fc_hold: assert property (!fwd_frame_tick_in[0] |=> $stable(fc_reg[0]))
        else $error("forward GPIO changed without a frame");
    a_fc_every_frame: assert property (fwd_frame_tick_in[0] && forward_slot_count_p0_in == 2'h0
        |=> fc_reg[0] == $past(fc_gpio_p0_in)) else $error("single GPIO not updated");
    a_pin3_open_drain: assert property (pin_out[3] == 1'b0 && input_en_reg[3]
        && !pulldown_reg[3]) else $error("pin 3 not open drain");
    a_reset_defaults: assert property ($rose(rst_n_reg) |-> input_en_reg == 8'h7f
        && pin_oe_out == 7'h00) else $error("pins not inputs after reset");
    c_fc_on_pin: cover property (pin_ctl_reg[0] == 8'h01 && pin_out[0]);
    c_fsync_slot: cover property (bc_frame_tick_in[0] && slot_map[2:0] == 3'h7);
    c_frame_ok: cover property (frame_valid_ok_out[0] && line_valid_ok_out[0]);
endmodule
`default_nettype wire

/* design/dgr_pin_mux.sv */
// Output level and drive selection for one pin
`timescale 1ns/1ps
`default_nettype none
module dgr_pin_mux (
    // Pin control byte
    input wire logic [7:0] ctl_in,
    // Status sources
    dgr_stat_if.dst st,
    // Selected drive and level
    output logic drive_out,
    output logic level_out
);
    logic [2:0] func;
    logic [2:0] src;
    logic [3:0] fc;
    logic p;
    assign func = ctl_in[dgr_pkg::CTL_FUNC_LSB +: 3];
    assign src = ctl_in[dgr_pkg::CTL_SRC_LSB +: 3];
    assign p = src[0];
    assign fc = p ? st.fc1 : st.fc0;

    // Source and function decode; reserved codes leave the pin undriven
    always_comb begin
        drive_out = ctl_in[dgr_pkg::CTL_EN_BIT];
        level_out = 1'b0;
        unique case (src)
            dgr_pkg::SRC_PORT0, dgr_pkg::SRC_PORT1: begin
                if (!func[2]) begin
                    level_out = fc[func[1:0]];
                end else begin
                    unique case (func[1:0])
                        2'h0: level_out = st.lock[p];
                        2'h1: level_out = st.pass[p];
                        2'h2: level_out = st.fv[p];
                        2'h3: level_out = st.lv[p];
                    endcase
                end
            end
            dgr_pkg::SRC_DEVICE: begin
                unique case (func)
                    3'h0: level_out = ctl_in[dgr_pkg::CTL_VAL_BIT];
                    3'h1: level_out = |(st.lock & st.en);
                    3'h2: level_out = &(st.lock | ~st.en);
                    3'h3: level_out = &(st.pass | ~st.en);
                    3'h4: level_out = st.fsync;
                    3'h5: level_out = st.irq;
                    3'h6: level_out = ~st.irq;
                    3'h7: drive_out = 1'b0;
                endcase
            end
            dgr_pkg::SRC_CSI: begin
                unique case (func)
                    3'h0: level_out = &(st.pass | ~st.en);
                    3'h1: level_out = |(st.pass & st.en);
                    3'h2: level_out = st.rec_fv;
                    3'h3: level_out = st.rec_lv;
                    3'h4: level_out = st.synced;
                    3'h5: level_out = st.csi_irq;
                    default: drive_out = 1'b0;
                endcase
            end
            default: drive_out = 1'b0;
        endcase
    end
endmodule
`default_nettype wire

/* dv/dgr_gpio_top_tb_top.sv */
// Self-checking bench for the pin routing block
`timescale 1ns/1ps
`default_nettype none
module dgr_gpio_top_tb_top;
    logic clk = 1'b0, rst_b = 1'b0, wr = 1'b0, rd = 1'b0;
    logic [7:0] addr = 8'h00, wd = 8'h00, rdat;
    logic [6:0] pin_i = 7'h55, po, poe, ppd;
    logic [1:0] en = 2'h3, lock = 2'h1, pass = 2'h3, fv = 2'h0, lv = 2'h0, bct = 2'h0;
    logic [1:0] fvok, lvok, cnt0 = 2'h0, cnt1 = 2'h0;
    logic [3:0] fc0, fc1, bc0, bc1;
    logic syn = 1'b1, fs = 1'b1, irq = 1'b1, csi = 1'b0;
    wire [1:0] ft;
    int mismatches = 0, total_checks = 0;
    // Rows: control byte, expected enable nibble, expected level nibble
    logic [15:0] rows [18] = '{16'h0000, 16'h1311, 16'h1110, 16'h3111, 16'h5110, 16'h7111,
        16'h9111, 16'hb111, 16'hd110, 16'hf100, 16'h8111, 16'h8510, 16'h0900, 16'hd500,
        16'h1511, 16'h9511, 16'h0111, 16'h6511};
    dgr_gpio_top DUT (.clock_in(clk), .rst_b_in(rst_b), .reg_addr_in(addr),
        .reg_wdata_in(wd), .reg_wr_in(wr), .reg_rd_in(rd), .reg_rd_data_out(rdat),
        .pin_in(pin_i), .pin_out(po), .pin_oe_out(poe), .pin_pulldown_out(ppd),
        .fc_gpio_p0_in(fc0), .fc_gpio_p1_in(fc1), .fwd_frame_tick_in(ft),
        .forward_slot_count_p0_in(cnt0), .forward_slot_count_p1_in(cnt1),
        .port_enable_in(en), .lock_in(lock), .pass_in(pass), .frame_valid_in(fv),
        .line_valid_in(lv), .ports_synced_in(syn), .frame_sync_pulse_in(fs),
        .dev_irq_in(irq), .csi_irq_in(csi), .bc_frame_tick_in(bct), .bc_slot_p0_out(bc0),
        .bc_slot_p1_out(bc1), .frame_valid_ok_out(fvok), .line_valid_ok_out(lvok));
    dgr_ser_model ser0 (.clock_in(clk), .gpio_in(4'h1), .fc_gpio_out(fc0), .tick_out(ft[0]));
    dgr_ser_model ser1 (.clock_in(clk), .gpio_in(4'h8), .fc_gpio_out(fc1), .tick_out(ft[1]));
    always #25 clk = ~clk;
    // Compare and count
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Register access, strobes launched off the sampling edge
    task automatic wreg(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk) {addr, wd, wr} = {a, d, 1'b1};
        @(negedge clk) wr = 1'b0;
    endtask
    task automatic rreg(input logic [7:0] a, input logic [7:0] e);
        @(negedge clk) {addr, rd} = {a, 1'b1};
        @(negedge clk) rd = 1'b0;
        chk(rdat, e);
    endtask
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    // Watchdog, well beyond the roughly 170 cycles the run needs
    initial begin
        #100000;
        mismatches++;
        report_and_stop();
    end
    // Main sequence
    initial begin
        repeat (10) @(negedge clk);
        rst_b = 1'b1;
        repeat (3) @(negedge clk);
        chk({1'b0, ppd}, 8'h77);
        chk({6'h0, po[3], poe[3]}, 8'h01);
        rreg(8'h0f, 8'h7f);
        rreg(8'hbe, 8'h77);
        rreg(8'hbc, 8'h80);
        rreg(8'h0e, 8'h55);
        rreg(8'h40, 8'h00);
        wreg(8'h0f, 8'h7e);
        foreach (rows[i]) begin
            wreg(8'h10, rows[i][15:8]);
            repeat (5) @(negedge clk);
            chk({7'h0, poe[0]}, {4'h0, rows[i][7:4]});
            if (rows[i][4]) chk({7'h0, po[0]}, {4'h0, rows[i][3:0]});
        end
        // Slot 0 from frame sync, slot 1 from pin 2, others from disabled pin 0
        wreg(8'h6e, 8'h27);
        @(negedge clk) bct = 2'h1;
        @(negedge clk) bct = 2'h0;
        @(negedge clk) chk({bc1, bc0}, 8'h03);
        // Line right at frame start is too early and must vanish
        @(negedge clk) {fv, lv} = 4'h5;
        repeat (3) @(negedge clk);
        chk({6'h0, lvok}, 8'h00);
        @(negedge clk) lv = 2'h0;
        @(negedge clk) lv = 2'h1;
        repeat (2) @(negedge clk);
        chk({6'h0, lvok}, 8'h01);
        wreg(8'h7c, 8'h01);
        repeat (3) @(negedge clk);
        chk({6'h0, fvok}, 8'h00);
        report_and_stop();
    end
endmodule
`default_nettype wire

/* dv/dgr_ser_model.sv */
// Remote serializer model sending forward-channel GPIO frames
`timescale 1ns/1ps
`default_nettype none
module dgr_ser_model (
    // Clock and levels to send
    input wire logic clock_in,
    input wire logic [3:0] gpio_in,
    // Forward channel toward the deserializer
    output logic [3:0] fc_gpio_out,
    output logic tick_out
);
    logic [1:0] div_reg = 2'h0;
    logic [3:0] gpio_reg = 4'h0;
    // One frame every four clocks; all four GPIOs travel as one unit
    always @(posedge clock_in) begin
        div_reg <= div_reg + 2'h1;
        if (div_reg == 2'h3) gpio_reg <= gpio_in;
    end
    // Frame marker lines up with the value refresh
    assign tick_out = (div_reg == 2'h3);
    assign fc_gpio_out = gpio_reg;
endmodule
`default_nettype wire

/* inc/dgr_pkg.sv */
// Constants shared by the pin routing block
package dgr_pkg;
    localparam int NPINS = 7;
    localparam int NPORTS = 2;
    localparam int NSLOTS = 4;
    // Register offsets
    localparam logic [7:0] OFF_PIN_STATUS = 8'h0e;
    localparam logic [7:0] OFF_INPUT_EN = 8'h0f;
    localparam logic [7:0] OFF_PIN0_CTL = 8'h10;
    localparam logic [7:0] OFF_PIN6_CTL = 8'h16;
    localparam logic [7:0] OFF_SLOT_LO = 8'h6e;
    localparam logic [7:0] OFF_SLOT_HI = 8'h6f;
    localparam logic [7:0] OFF_SYNC_POL = 8'h7c;
    localparam logic [7:0] OFF_FV_MIN = 8'hbc;
    localparam logic [7:0] OFF_PULLDOWN = 8'hbe;
    // Pin control field positions
    localparam int CTL_EN_BIT = 0;
    localparam int CTL_VAL_BIT = 1;
    localparam int CTL_SRC_LSB = 2;
    localparam int CTL_FUNC_LSB = 5;
    // Values after reset
    localparam logic [7:0] RST_INPUT_EN = 8'h7f;
    localparam logic [7:0] RST_PULLDOWN = 8'h77;
    localparam logic [7:0] RST_PIN_CTL = 8'h00;
    localparam logic [7:0] RST_SLOT = 8'h00;
    localparam logic [7:0] RST_SYNC_POL = 8'h00;
    localparam logic [7:0] RST_FV_MIN = 8'h80;
    // Open-drain pin shared with the interrupt
    localparam int INT_PIN = 3;
    // Sync polarity config: bit 2p inverts frame valid, 2p+1 line valid
    localparam int KEEP_LSB = 4;
    // Slot select value that picks frame sync instead of a pin
    localparam logic [2:0] SLOT_FSYNC = 3'h7;
    // Forward frames per GPIO update for 1, 2 and 3-4 linked GPIOs
    localparam logic [2:0] FWD_DIV_ONE = 3'h1;
    localparam logic [2:0] FWD_DIV_TWO = 3'h2;
    localparam logic [2:0] FWD_DIV_MANY = 3'h5;
    typedef enum logic [2:0] {
        SRC_PORT0 = 3'h0,
        SRC_PORT1 = 3'h1,
        SRC_DEVICE = 3'h4,
        SRC_CSI = 3'h5
    } dgr_src_t;
    typedef enum logic [1:0] {
        Q_IDLE = 2'h0,
        Q_COUNT = 2'h1,
        Q_LINE = 2'h3,
        Q_DROP = 2'h2
    } dgr_qual_t;
endpackage

/* inc/dgr_stat_if.sv */
// Status bundle fed to every pin output selector
`timescale 1ns/1ps
`default_nettype none
interface dgr_stat_if;
    logic [3:0] fc0;
    logic [3:0] fc1;
    logic [1:0] lock;
    logic [1:0] pass;
    logic [1:0] fv;
    logic [1:0] lv;
    logic [1:0] en;
    logic fsync;
    logic irq;
    logic csi_irq;
    logic synced;
    logic rec_fv;
    logic rec_lv;
    modport src (output fc0, fc1, lock, pass, fv, lv, en, fsync, irq, csi_irq, synced,
        rec_fv, rec_lv);
    modport dst (input fc0, fc1, lock, pass, fv, lv, en, fsync, irq, csi_irq, synced,
        rec_fv, rec_lv);
endinterface
`default_nettype wire
